// [bench/afc_far_model.sv]
// Far-side model: interface request source and conversion datapath
module afc_far_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [3:0] cmd_i,
  input wire logic slow_i,
  input wire logic seq_start_i,
  input wire logic abort_i,
  output logic [3:0] if_req_o,
  output logic conv_done_o,
  output logic list_end_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] hold_r;
  logic [3:0] run_r;
  logic [1:0] idx_r;
  // Hold a request 5 cycles so the two-stage sync sees a clean rise
  always_ff @(posedge clk_i) begin
    if (rst_i || (cmd_i == 4'h0 && hold_r == 3'h0)) begin
      if_req_o <= 4'h0;
      hold_r <= 3'h0;
    end else if (cmd_i != 4'h0) begin
      if_req_o <= cmd_i;
      hold_r <= 3'h4;
    end else begin
      hold_r <= hold_r - 3'h1;
    end
  end
  // Sequence lasts 2 or 12 cycles; every third one ends the list
  always_ff @(posedge clk_i) begin
    if (rst_i || abort_i) begin
      run_r <= 4'h0;
    end else begin
      run_r <= seq_start_i ? (slow_i ? 4'hC : 4'h2)
        : run_r - 4'(run_r != 4'h0);
    end
    if (rst_i) begin
      idx_r <= 2'h0;
    end else if (conv_done_o) begin
      idx_r <= (idx_r == 2'h2) ? 2'h0 : idx_r + 2'h1;
    end
  end
  assign conv_done_o = run_r == 4'h1;
  assign list_end_o = conv_done_o && idx_r == 2'h2;
endmodule

// [bench/afc_flow_checker.sv]
// Port-level assertion checker for the flow control block
module afc_flow_checker
  import afc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic ack_o,
  input wire logic [3:0] if_req_i,
  input wire logic seq_start_o,
  input wire logic load_top_o,
  input wire logic abort_o,
  input wire logic busy_o,
  input wire logic irq_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [5:0] ctl_r;
  logic wr_ok;
  // Write lands at ack; mirror control so flow checks know the mode
  assign wr_ok = cyc_i && stb_i && we_i && ack_o && sel_i[0];
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl_r <= 6'h00;
    end else if (wr_ok && adr_i == AFC_CTRL_ADDR) begin
      ctl_r <= dat_i[5:0];
    end
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // Flow write of one pattern while enabled with bus access
  sequence s_flow(v);
    wr_ok && adr_i == AFC_FLOW_ADDR && dat_i[3:0] == v
      && ctl_r[AFC_CTRL_EN] && ctl_r[AFC_CTRL_ACC_LO];
  endsequence
  chk_ack_next: assert property (
    cyc_i && stb_i && !ack_o |=> ack_o) else $error("ack missing");
  chk_ack_pulse: assert property (
    ack_o |=> !ack_o) else $error("ack held");
  chk_reset_quiet: assert property (disable iff (1'b0)
    rst_i |=> !(seq_start_o || load_top_o || abort_o || busy_o || irq_o))
    else $error("output active after reset");
  // Idle is judged before ack: the restart timer already runs at ack
  chk_restart_top: assert property (
    !busy_o ##1 s_flow(4'h1) |-> ##[1:8] load_top_o)
    else $error("no top load");
  chk_auto_trigger_request: assert property (
    !busy_o ##1 s_flow(4'h1) ##0 ctl_r[AFC_CTRL_TRGMODE]
    |-> ##[2:12] seq_start_o) else $error("no automatic trigger");
  chk_trigger_request_start: assert property (
    s_flow(4'h2) ##0 !busy_o |-> ##[1:8] seq_start_o)
    else $error("trigger did not start");
  chk_abort_go: assert property (
    s_flow(4'h4) ##0 busy_o |-> abort_o)
    else $error("abort not issued");
  chk_abort_idle: assert property (
    s_flow(4'hD) ##0 busy_o |-> ##[2:12] !busy_o)
    else $error("abort left block busy");
  chk_if_restart: assert property (
    $rose(if_req_i[AFC_REQ_RST]) && if_req_i[3:1] == 3'h0
      && ctl_r[AFC_CTRL_EN] && ctl_r[AFC_CTRL_ACC_LO + 1] && !busy_o
    |-> ##[2:10] load_top_o) else $error("interface restart lost");
endmodule

bind afc_flow_ctrl afc_flow_checker chk_u (.clk_i, .rst_i, .cyc_i, .stb_i,
  .we_i, .adr_i, .sel_i, .dat_i, .ack_o, .if_req_i, .seq_start_o,
  .load_top_o, .abort_o, .busy_o, .irq_o);

// [bench/afc_flow_ctrl_tb.sv]
// Self-checking bench for the flow control block
module afc_flow_ctrl_tb
  import afc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0;
  logic we_i = 1'b0, slow = 1'b0, ab_q = 1'b0, a0, ack_o, irq_o, busy_o;
  logic list_end_i, conv_done_i, seq_start_o, load_top_o, abort_o;
  logic active_list_o;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'hF, cmd = 4'h0, if_req_i;
  logic [31:0] dat_i = 32'h0, dat_o, q;
  int fails = 0, n_tests = 0, n_seq = 0, n_top = 0, n_abt = 0, s, t, tn;
  logic [7:0] ra [6] = '{AFC_CTRL_ADDR, AFC_FLOW_ADDR, AFC_STAT_ADDR,
    AFC_IFLG_ADDR, AFC_IMSK_ADDR, 8'h14};
  afc_flow_ctrl dut_u (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
    .sel_i, .dat_i, .dat_o, .ack_o, .if_req_i, .list_end_i, .conv_done_i,
    .seq_start_o, .load_top_o, .abort_o, .active_list_o, .busy_o, .irq_o);
  afc_far_model far_u (.clk_i, .rst_i, .cmd_i(cmd), .slow_i(slow),
    .seq_start_i(seq_start_o), .abort_i(abort_o), .if_req_o(if_req_i),
    .conv_done_o(conv_done_i), .list_end_o(list_end_i));
  // 100 ns clock
  always #50 clk_i = ~clk_i;
  // Pulse tallies; abort counted on its rise in case it lasts
  always @(posedge clk_i) begin
    n_seq <= n_seq + int'(seq_start_o === 1'b1);
    n_top <= n_top + int'(load_top_o === 1'b1);
    n_abt <= n_abt + int'(abort_o === 1'b1 && !ab_q);
    ab_q <= abort_o === 1'b1;
  end
  function automatic logic [31:0] acc_exp(int a);
    return 32'(((a >> 1) >> (a % 2)) & 1);
  endfunction
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %0t got %h want %h", $time, g, e);
    end
  endtask
  // Request held until ack is sampled; the wait is bounded
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] v);
    int k;
    k = 0;
    {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, v};
    do begin
      @(posedge clk_i);
      k++;
    end while (ack_o !== 1'b1 && k < 20);
    q = dat_o;
    {cyc_i, stb_i} <= 2'b00;
    if (k >= 20) begin
      fails++;
      conclude();
    end
    @(posedge clk_i);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  // Busy must stay low 4 cycles, since a trigger may follow a restart
  task automatic idle();
    int k, low;
    k = 0;
    low = 0;
    repeat (4) @(posedge clk_i);
    while (low < 4 && k < 300) begin
      @(posedge clk_i);
      k++;
      low = (busy_o === 1'b0) ? low + 1 : 0;
    end
    if (k >= 300) begin
      fails++;
      conclude();
    end
  endtask
  task automatic tend();
    tn++;
    $display("test %0d done", tn);
  endtask
  // Main sequence
  initial begin
    tn = 0;
    void'($urandom(33));
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    foreach (ra[i]) rdc(ra[i], 32'h0);
    tend();
    wb(1'b1, AFC_CTRL_ADDR, 32'h13);
    {s, t} = {n_seq, n_top};
    wb(1'b1, AFC_FLOW_ADDR, 32'h1);
    idle();
    chk(n_top - t, 1);
    chk(n_seq - s, 1);
    rdc(AFC_FLOW_ADDR, 32'h0);
    for (int i = 0; i < 4; i++) begin
      slow <= 1'($urandom_range(0, 1));
      s = n_seq;
      wb(1'b1, AFC_FLOW_ADDR, 32'h2);
      idle();
      chk(n_seq - s, 1);
    end
    wb(1'b1, AFC_IMSK_ADDR, 32'h10);
    wb(1'b1, AFC_FLOW_ADDR, 32'h3);
    repeat (8) @(posedge clk_i);
    rdc(AFC_IFLG_ADDR, 32'h10);
    chk(irq_o, 1'b1);
    wb(1'b1, AFC_CTRL_ADDR, 32'h0);
    wb(1'b1, AFC_IFLG_ADDR, 32'h10);
    chk(irq_o, 1'b0);
    tend();
    wb(1'b1, AFC_CTRL_ADDR, 32'h11);
    // Trigger left pending by the failed restart runs once on re-enable
    idle();
    wb(1'b1, AFC_FLOW_ADDR, 32'h3);
    idle();
    rdc(AFC_IFLG_ADDR, 32'h1);
    chk(irq_o, 1'b0);
    wb(1'b1, AFC_IFLG_ADDR, 32'h1F);
    {s, t} = {n_seq, n_top};
    wb(1'b1, AFC_FLOW_ADDR, 32'h1);
    idle();
    wb(1'b1, AFC_FLOW_ADDR, 32'h2);
    idle();
    chk(n_top - t, 1);
    chk(n_seq - s, 1);
    wb(1'b1, AFC_CTRL_ADDR, 32'h15);
    {a0, s} = {active_list_o, n_seq};
    wb(1'b1, AFC_FLOW_ADDR, 32'h8);
    idle();
    wb(1'b1, AFC_FLOW_ADDR, 32'h6);
    idle();
    chk(active_list_o, a0);
    chk(n_seq - s, 0);
    // Lone abort still completes, so only abort-done may show
    rdc(AFC_IFLG_ADDR, 32'h08);
    wb(1'b1, AFC_IFLG_ADDR, 32'h1F);
    wb(1'b1, AFC_FLOW_ADDR, 32'h9);
    idle();
    chk(active_list_o, 32'(!a0));
    tend();
    // Slow sequences so the abort always lands mid-run
    wb(1'b1, AFC_CTRL_ADDR, 32'h11);
    wb(1'b1, AFC_IMSK_ADDR, 32'h08);
    slow <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, AFC_FLOW_ADDR, 32'h1);
      idle();
      t = n_abt;
      wb(1'b1, AFC_FLOW_ADDR, 32'h2);
      repeat ($urandom_range(3, 5)) @(posedge clk_i);
      // Mid-run status: swapped list, sequence running, busy
      rdc(AFC_STAT_ADDR, {29'h0, !a0, 2'b11});
      wb(1'b1, AFC_FLOW_ADDR, $urandom_range(0, 1) ? 32'hD : 32'h4);
      idle();
      chk(n_abt - t, 1);
      rdc(AFC_FLOW_ADDR, 32'h0);
      chk(irq_o, 1'b1);
      rdc(AFC_IFLG_ADDR, 32'h08);
      wb(1'b1, AFC_IFLG_ADDR, 32'h1F);
      chk(irq_o, 1'b0);
    end
    slow <= 1'b0;
    for (int a = 0; a < 8; a++) begin
      wb(1'b1, AFC_CTRL_ADDR, 32'(((a >> 1) << AFC_CTRL_ACC_LO) | 1));
      t = n_top;
      if (a % 2 == 1) begin
        cmd <= 4'h1;
        @(posedge clk_i);
        cmd <= 4'h0;
      end else begin
        wb(1'b1, AFC_FLOW_ADDR, 32'h1);
      end
      idle();
      chk(n_top - t, acc_exp(a));
    end
    tend();
    conclude();
  end
endmodule

// [hdl/afc_delay.sv]
// Completion timer for restart and abort events
module afc_delay
  import afc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  output logic busy_o,
  output logic done_o
);
  logic [3:0] cnt_r;

  // Counts down a fixed latency after start
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r <= 4'h0;
    end else if (start_i) begin
      cnt_r <= AFC_DONE_CNT;
    end else if (cnt_r != 4'h0) begin
      cnt_r <= cnt_r - 4'h1;
    end
  end

  assign busy_o = (cnt_r != 4'h0);
  assign done_o = (cnt_r == 4'h1);
endmodule

// [hdl/afc_flow_ctrl.sv]
// Conversion flow control block with Wishbone register slave
module afc_flow_ctrl
  import afc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic [3:0] if_req_i,
  input wire logic list_end_i,
  input wire logic conv_done_i,
  output logic seq_start_o,
  output logic load_top_o,
  output logic abort_o,
  output logic active_list_o,
  output logic busy_o,
  output logic irq_o
);
  // ---------------------------------------------------------------
  // Registers and nets
  // ---------------------------------------------------------------
  logic [31:0] ctrl_r;
  logic [3:0] flow_r;
  logic [AFC_NFLAG-1:0] flag_r;
  logic [AFC_NFLAG-1:0] mask_r;
  logic [3:0] ifreq_s1_r;
  logic [3:0] ifreq_s2_r;
  logic [3:0] ifreq_d_r;
  logic ack_r;
  logic [31:0] dat_r;
  logic list_r;
  logic top_r;
  logic seq_r;
  logic abort_r;
  logic start_r;
  afc_state_t state_r;
  afc_state_t state_nxt;
  logic [3:0] bus_req;
  logic [3:0] if_req;
  logic [3:0] req;
  logic [AFC_NFLAG-1:0] set_flag;
  logic wr_req;
  logic rd_req;
  logic en;
  logic trg_mode;
  logic rst_busy;
  logic rst_done;
  logic abt_busy;
  logic abt_done;
  logic new_rst;
  logic new_trg;
  logic new_abt;
  logic new_ld;
  logic trg_ok;

  // Byte lane merge for writes
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // ---------------------------------------------------------------
  // Bus slave: one wait state, ack drops after one cycle
  // ---------------------------------------------------------------
  assign wr_req = cyc_i && stb_i && we_i && !ack_r;
  assign rd_req = cyc_i && stb_i && !we_i && !ack_r;
  assign en = ctrl_r[AFC_CTRL_EN];
  assign trg_mode = ctrl_r[AFC_CTRL_TRGMODE];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= cyc_i && stb_i && !ack_r;
    end
  end
  assign ack_o = ack_r;

  // Read data; unmapped addresses read zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_r <= 32'h0000_0000;
    end else if (rd_req) begin
      case (adr_i)
        AFC_CTRL_ADDR: dat_r <= ctrl_r;
        AFC_FLOW_ADDR: dat_r <= {28'h0, flow_r};
        AFC_STAT_ADDR: dat_r <= {29'h0, list_r, seq_r, busy_o};
        AFC_IFLG_ADDR: dat_r <= {27'h0, flag_r};
        AFC_IMSK_ADDR: dat_r <= {27'h0, mask_r};
        default: dat_r <= 32'h0000_0000;
      endcase
    end
  end
  assign dat_o = dat_r;

  // Control register; converter comes up disabled
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= AFC_CTRL_RST; // R12
    end else if (wr_req && adr_i == AFC_CTRL_ADDR) begin
      ctrl_r <= merge(ctrl_r, dat_i, sel_i) & 32'h0000_0037;
    end
  end

  // Interrupt mask
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_r <= '0;
    end else if (wr_req && adr_i == AFC_IMSK_ADDR && sel_i[0]) begin
      mask_r <= dat_i[AFC_NFLAG-1:0];
    end
  end

  // ---------------------------------------------------------------
  // Request sources
  // ---------------------------------------------------------------
  // Interface requests treated as async: two-stage sync then edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ifreq_s1_r <= 4'h0;
      ifreq_s2_r <= 4'h0;
      ifreq_d_r <= 4'h0;
    end else begin
      ifreq_s1_r <= if_req_i;
      ifreq_s2_r <= ifreq_s1_r;
      ifreq_d_r <= ifreq_s2_r;
    end
  end

  assign bus_req = (wr_req && adr_i == AFC_FLOW_ADDR && sel_i[0]) ?
                   dat_i[3:0] : 4'h0;
  assign if_req = ifreq_s2_r & ~ifreq_d_r;

  afc_req_sel u_sel (
    .acc_sel_i(ctrl_r[AFC_CTRL_ACC_LO +: 2]),
    .bus_req_i(bus_req),
    .if_req_i(if_req),
    .req_o(req)
  );

  // Requests only while enabled and not failed
  always_comb begin
    new_rst = 1'b0;
    new_trg = 1'b0;
    new_abt = 1'b0;
    new_ld = 1'b0;
    if (en && state_r != AFC_FAILED) begin
      new_rst = req[AFC_REQ_RST];
      new_abt = req[AFC_REQ_ABT];
      // Load-ok meaningful only with a restart
      new_ld = req[AFC_REQ_LIST_LOAD_OK] && req[AFC_REQ_RST]; // R17
      // Trigger plus abort without restart dropped
      new_trg = req[AFC_REQ_TRG] &&
                !(req[AFC_REQ_ABT] && !req[AFC_REQ_RST]); // R17
    end
  end

  // ---------------------------------------------------------------
  // Event timers
  // ---------------------------------------------------------------
  afc_delay u_rst_tmr (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(new_rst && !rst_busy),
    .busy_o(rst_busy),
    .done_o(rst_done)
  );

  afc_delay u_abt_tmr (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(new_abt && !abt_busy),
    .busy_o(abt_busy),
    .done_o(abt_done)
  );

  // ---------------------------------------------------------------
  // Flow request bits, cleared by the block itself
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flow_r <= 4'h0;
    end else begin
      if (new_rst) begin
        flow_r[AFC_REQ_RST] <= 1'b1;
      end else if (rst_done) begin
        flow_r[AFC_REQ_RST] <= 1'b0; // R15
      end
      if (new_abt) begin
        flow_r[AFC_REQ_ABT] <= 1'b1;
      end else if (abt_done) begin
        flow_r[AFC_REQ_ABT] <= 1'b0; // R14
      end
      if (new_ld) begin
        flow_r[AFC_REQ_LIST_LOAD_OK] <= 1'b1;
      end else if (rst_done) begin
        flow_r[AFC_REQ_LIST_LOAD_OK] <= 1'b0;
      end
      // Trigger mode: restart sets trigger too
      if (new_trg || (new_rst && trg_mode)) begin
        flow_r[AFC_REQ_TRG] <= 1'b1; // R2
      end else if (start_r) begin
        flow_r[AFC_REQ_TRG] <= 1'b0;
      end
    end
  end

  // Trigger accepted once no restart or abort pending
  assign trg_ok = flow_r[AFC_REQ_TRG] && !rst_busy && !abt_busy &&
                  !flow_r[AFC_REQ_RST] && state_r == AFC_IDLE; // R5

  // ---------------------------------------------------------------
  // Sequence state
  // ---------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      AFC_IDLE: begin
        if (trg_ok) begin
          state_nxt = AFC_RUN; // R8
        end
      end
      AFC_RUN: begin
        if (new_abt || conv_done_i || list_end_i) begin
          state_nxt = AFC_IDLE; // R9
        end
      end
      AFC_FAILED: state_nxt = AFC_FAILED;
      default: state_nxt = AFC_IDLE;
    endcase
    // Restart with trigger in trigger mode stops the converter
    if (trg_mode && new_rst && req[AFC_REQ_TRG]) begin
      state_nxt = AFC_FAILED; // R3
    end
    if (!en) begin
      state_nxt = AFC_IDLE;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= AFC_IDLE; // R12
    end else begin
      state_r <= state_nxt;
    end
  end

  // Start pulse, abort pulse, list-top load pulse
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      start_r <= 1'b0;
      abort_r <= 1'b0;
      top_r <= 1'b0;
      seq_r <= 1'b0;
    end else begin
      start_r <= (state_r == AFC_IDLE) && (state_nxt == AFC_RUN); // R8
      abort_r <= new_abt; // R9
      // Restart, or list end in trigger mode, rewinds the list
      top_r <= rst_done ||
               (trg_mode && list_end_i && state_r == AFC_RUN); // R7 R4
      seq_r <= (state_nxt == AFC_RUN);
    end
  end

  // Active list swaps on restart with load-ok in double buffer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      list_r <= 1'b0;
    end else if (rst_done && flow_r[AFC_REQ_LIST_LOAD_OK] &&
                 ctrl_r[AFC_CTRL_DBUF]) begin
      list_r <= ~list_r; // R11
    end
  end

  // ---------------------------------------------------------------
  // Sticky flags; hardware set wins over write-one clear
  // ---------------------------------------------------------------
  always_comb begin
    set_flag = '0;
    set_flag[AFC_F_TRGERR] = !trg_mode && new_rst &&
                             req[AFC_REQ_TRG]; // R6
    // Restart while running or restarting is an error unless abort comes too
    set_flag[AFC_F_RSTERR] = new_rst && !new_abt &&
                             (state_r == AFC_RUN || rst_busy); // R10
    set_flag[AFC_F_LDERR] = new_ld && !new_abt &&
                            (state_r == AFC_RUN || rst_busy); // R10
    set_flag[AFC_F_ABTDONE] = abt_done; // R16
    set_flag[AFC_F_FAIL] = (state_nxt == AFC_FAILED) &&
                           (state_r != AFC_FAILED);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_r <= '0;
    end else if (wr_req && adr_i == AFC_IFLG_ADDR && sel_i[0]) begin
      flag_r <= (flag_r & ~dat_i[AFC_NFLAG-1:0]) | set_flag;
    end else begin
      flag_r <= flag_r | set_flag;
    end
  end

  // Level interrupt from unmasked flags
  assign irq_o = |(flag_r & mask_r);

  assign seq_start_o = start_r;
  assign load_top_o = top_r;
  assign abort_o = abort_r;
  assign active_list_o = list_r;
  assign busy_o = (state_r == AFC_RUN) || rst_busy || abt_busy;
endmodule

// [hdl/afc_req_sel.sv]
// Request source selector: merges bus and interface requests
module afc_req_sel
  import afc_pkg::*;
(
  input wire logic [1:0] acc_sel_i,
  input wire logic [3:0] bus_req_i,
  input wire logic [3:0] if_req_i,
  output logic [3:0] req_o
);
  // Each source gated by its own access enable
  always_comb begin
    req_o = 4'h0;
    if (acc_sel_i == AFC_ACC_BUS || acc_sel_i == AFC_ACC_BOTH) begin
      req_o = req_o | bus_req_i; // R1 R13
    end
    if (acc_sel_i == AFC_ACC_IF || acc_sel_i == AFC_ACC_BOTH) begin
      req_o = req_o | if_req_i; // R1 R13
    end
  end
endmodule

// [shared/afc_pkg.sv]
// Package of constants and types for the conversion flow control block
// Notes on behaviour
// R1: Each request bit from bus and/or interface
// R2: Trigger mode: restart also sets trigger
// R3: Trigger mode: requester never sends restart+trigger
// R4: Trigger mode: list end returns to top
// R5: Restart mode: restart, finish, then trigger
// R6: Restart mode: restart+trigger sets trigger error
// R7: Restart loads command from list top
// R8: Accepted trigger starts a conversion sequence
// R9: Abort ends conversion, sequence and list
// R10: Abort with restart suppresses two errors
// R11: Double buffer: load-ok with restart swaps lists
// R12: Reset leaves converter disabled, bits cleared
// R13: Access select: bus, interface, or both
// R14: Abort bit self-clears once idle
// R15: Restart bit self-clears when restart finished
// R16: Abort-done flag with its own enable
// R17: Ignore load-ok or trigger+abort without restart
package afc_pkg;
  // ---------------------------------------------------------------
  // Register byte addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] AFC_CTRL_ADDR = 8'h00;
  localparam logic [7:0] AFC_FLOW_ADDR = 8'h04;
  localparam logic [7:0] AFC_STAT_ADDR = 8'h08;
  localparam logic [7:0] AFC_IFLG_ADDR = 8'h0C;
  localparam logic [7:0] AFC_IMSK_ADDR = 8'h10;
  // ---------------------------------------------------------------
  // Control register fields
  // ---------------------------------------------------------------
  localparam int AFC_CTRL_EN = 0;
  localparam int AFC_CTRL_TRGMODE = 1;
  localparam int AFC_CTRL_DBUF = 2;
  localparam int AFC_CTRL_ACC_LO = 4;
  localparam logic [31:0] AFC_CTRL_RST = 32'h0000_0000;
  // ---------------------------------------------------------------
  // Flow request bits (flow register and interface vector)
  // ---------------------------------------------------------------
  localparam int AFC_REQ_RST = 0;
  localparam int AFC_REQ_TRG = 1;
  localparam int AFC_REQ_ABT = 2;
  localparam int AFC_REQ_LIST_LOAD_OK = 3;
  // ---------------------------------------------------------------
  // Flag bits (status flag and mask registers)
  // ---------------------------------------------------------------
  localparam int AFC_F_TRGERR = 0;
  localparam int AFC_F_RSTERR = 1;
  localparam int AFC_F_LDERR = 2;
  localparam int AFC_F_ABTDONE = 3;
  localparam int AFC_F_FAIL = 4;
  localparam int AFC_NFLAG = 5;
  // ---------------------------------------------------------------
  // Access select encodings
  // ---------------------------------------------------------------
  localparam logic [1:0] AFC_ACC_NONE = 2'h0;
  localparam logic [1:0] AFC_ACC_BUS = 2'h1;
  localparam logic [1:0] AFC_ACC_IF = 2'h2;
  localparam logic [1:0] AFC_ACC_BOTH = 2'h3;
  // ---------------------------------------------------------------
  // Timing: restart and abort completion latency
  // ---------------------------------------------------------------
  localparam int AFC_CLK_MHZ = 10;
  localparam int AFC_DONE_NS = 300;
  localparam int AFC_DONE_CYC = (AFC_DONE_NS * AFC_CLK_MHZ + 999) / 1000;
  localparam logic [3:0] AFC_DONE_CNT = 4'(AFC_DONE_CYC);

  typedef enum logic [1:0] {
    AFC_IDLE,
    AFC_RUN,
    AFC_FAILED
  } afc_state_t;
endpackage
